// [logic/psd_datapath.sv]
/*
 Top of the packed-integer SIMD datapath: one issue per cycle, result registered.
 Assumes decode presents op, operands and immediate with a one-cycle valid strobe.
 // Operation
 // - Odd-lane duplicate copies 32-bit elements one and three into both pair slots.
 // - Even-lane duplicate copies 32-bit elements zero and two into both pair slots.
 // - Quad duplicate writes source low 64 bits into both result halves.
 // - Horizontal word add sums adjacent 16-bit pairs; saturating variant clamps.
 // - Horizontal dword add sums adjacent 32-bit pairs from both operands.
 // - Horizontal word subtract computes low minus high; saturating variant clamps.
 // - Horizontal dword subtract computes low minus high for 32-bit pairs.
 // - Absolute value replaces each byte, word or dword with its magnitude.
 // - Byte multiply-add: unsigned times signed, pair sums saturate to 16 bits.
 // - Rounded high multiply keeps top 18 bits of each 32-bit product.
 // - Add one to the 18-bit value, output the 16 bits below its top.
 // - Shuffle index is low three or four bits of the control byte.
 // - Control byte top bit set forces the result byte to zero.
 // - Shuffle leaves the control mask operand unchanged.
 // - Conditional sign negates destination element when source element is negative.
 // - Align right shifts destination-over-source right by immediate bytes, keeps low part.
*/
`timescale 1ns/10ps
module psd_datapath (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         clk_en,
    // Issue
    input  wire logic         issue_valid,
    input  wire psd_pkg::psd_op_t op,
    input  wire logic         wide,
    input  wire logic [127:0] dst_in,
    input  wire logic [127:0] src_in,
    input  wire logic [7:0]   imm,
    // Result
    output logic              res_valid,
    output logic [127:0]      res_data,
    output logic [127:0]      src_out
);
    psd_op_if opif ();

    logic [127:0] shuf_w;
    logic [127:0] align_w;
    logic [127:0] res_w;
    logic [127:0] res_data_r;
    logic [127:0] src_out_r;
    logic         res_valid_r;

    assign opif.op   = op;
    assign opif.wide = wide;
    assign opif.dst  = dst_in;
    assign opif.src  = src_in;

    psd_lanes u_lanes (
        .io (opif.alu)
    );

    psd_shuffle #(.NBYTES(16)) u_shuf (
        .dst       (dst_in),
        .src       (src_in),
        .imm       (imm),
        .wide      (wide),
        .shuf_res  (shuf_w),
        .align_res (align_w)
    );

    assign res_w = (op == psd_pkg::PSD_BYTE_SHUFFLE)
                   ? (wide ? shuf_w : {64'h0, shuf_w[63:0]})
                   : (op == psd_pkg::PSD_ALIGN_RIGHT_CONCAT) ? align_w : opif.res;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            res_valid_r <= 1'b0;
            res_data_r  <= 128'h0;
            src_out_r   <= 128'h0;
        end else if (clk_en) begin
            res_valid_r <= issue_valid;
            if (issue_valid) begin
                res_data_r <= res_w;
                src_out_r  <= src_in;
            end
        end
    end

    assign res_valid = res_valid_r;
    assign res_data  = res_data_r;
    assign src_out   = src_out_r;
endmodule : psd_datapath

// [logic/psd_lanes.sv]
/*
 Lane arithmetic for the packed-integer datapath: duplicates, horizontal add and subtract,
 absolute value, multiply-add, rounded high multiply and conditional sign.
 Assumes the caller presents operands through the interface and registers the result.
*/
`timescale 1ns/10ps
module psd_lanes (
    // Operation and operands
    psd_op_if.alu io
);
    function automatic logic [15:0] sat16(input logic signed [17:0] v);
        if (v > 18'sd32767) return 16'h7FFF;
        if (v < -18'sd32768) return 16'h8000;
        return v[15:0];
    endfunction : sat16

    function automatic logic [31:0] sgn(input logic [31:0] d, input logic [31:0] s, int w);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 32; i++) begin
            if (i < w) m[i] = 1'b1;
        end
        if (s[w-1]) return (32'(-d)) & m;
        if ((s & m) == 32'h0) return 32'h0;
        return d & m;
    endfunction : sgn

    logic [127:0] dst_w;
    logic [127:0] src_w;
    logic [127:0] hw_add;
    logic [127:0] hw_adds;
    logic [127:0] hw_sub;
    logic [127:0] hw_subs;
    logic [127:0] hd_add;
    logic [127:0] hd_sub;
    logic [127:0] abs_b;
    logic [127:0] abs_w;
    logic [127:0] abs_d;
    logic [127:0] madd;
    logic [127:0] mhrs;
    logic [127:0] sg_b;
    logic [127:0] sg_w;
    logic [127:0] sg_d;
    logic [255:0] pair_w;

    // Narrow mode packs destination pairs then source pairs in the low 128 bits.
    assign dst_w  = io.dst;
    assign src_w  = io.src;
    assign pair_w = io.wide ? {src_w, dst_w} : {128'h0, src_w[63:0], dst_w[63:0]};

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_hw
            wire logic signed [15:0] lo = pair_w[32*g +: 16];
            wire logic signed [15:0] hi = pair_w[32*g+16 +: 16];
            wire logic signed [17:0] sm = 18'(lo) + 18'(hi);
            wire logic signed [17:0] df = 18'(lo) - 18'(hi);
            if (g < 8) begin : g_put
                wire logic [15:0] a_v  = sm[15:0];
                wire logic [15:0] as_v = sat16(sm);
                wire logic [15:0] s_v  = df[15:0];
                wire logic [15:0] ss_v = sat16(df);
            end
        end
        for (g = 0; g < 8; g++) begin : g_hwp
            localparam int P = g;
            assign hw_add[16*P +: 16]  = g_hw[P].g_put.a_v;
            assign hw_adds[16*P +: 16] = g_hw[P].g_put.as_v;
            assign hw_sub[16*P +: 16]  = g_hw[P].g_put.s_v;
            assign hw_subs[16*P +: 16] = g_hw[P].g_put.ss_v;
        end
        for (g = 0; g < 4; g++) begin : g_hd
            wire logic [31:0] lo = pair_w[64*g +: 32];
            wire logic [31:0] hi = pair_w[64*g+32 +: 32];
            assign hd_add[32*g +: 32] = lo + hi;
            assign hd_sub[32*g +: 32] = lo - hi;
        end
        for (g = 0; g < 16; g++) begin : g_b
            wire logic signed [7:0] sb = src_w[8*g +: 8];
            wire logic [7:0]        ab = sb[7] ? 8'(-sb) : sb;
            assign abs_b[8*g +: 8] = ab;
            wire logic [31:0] sgv = sgn({24'h0, dst_w[8*g +: 8]}, {24'h0, src_w[8*g +: 8]}, 8);
            assign sg_b[8*g +: 8] = sgv[7:0];
        end
        for (g = 0; g < 8; g++) begin : g_w
            wire logic signed [15:0] sw = src_w[16*g +: 16];
            assign abs_w[16*g +: 16] = sw[15] ? 16'(-sw) : sw;
            wire logic signed [15:0] ua = $signed({1'b0, dst_w[16*g +: 8]})
                                          * $signed(src_w[16*g +: 8]);
            wire logic signed [15:0] ub = $signed({1'b0, dst_w[16*g+8 +: 8]})
                                          * $signed(src_w[16*g+8 +: 8]);
            assign madd[16*g +: 16] = sat16(18'(ua) + 18'(ub));
            wire logic signed [31:0] pr = $signed(dst_w[16*g +: 16])
                                          * $signed(src_w[16*g +: 16]);
            wire logic [17:0]        t18 = pr[psd_pkg::MHI_TOP:psd_pkg::MHI_LSB];
            wire logic [17:0]        r18 = t18 + 18'(psd_pkg::RND_INC);
            assign mhrs[16*g +: 16] = r18[16:1];
            wire logic [31:0] sgv = sgn({16'h0, dst_w[16*g +: 16]},
                                        {16'h0, src_w[16*g +: 16]}, 16);
            assign sg_w[16*g +: 16] = sgv[15:0];
        end
        for (g = 0; g < 4; g++) begin : g_d
            wire logic signed [31:0] sd = src_w[32*g +: 32];
            assign abs_d[32*g +: 32] = sd[31] ? 32'(-sd) : sd;
            assign sg_d[32*g +: 32] = sgn(dst_w[32*g +: 32], src_w[32*g +: 32], 32);
        end
    endgenerate

    logic [127:0] sel;
    always_comb begin
        case (io.op)
            psd_pkg::PSD_ODD_LANE_DUP_MOVE:
                sel = {src_w[127:96], src_w[127:96], src_w[63:32], src_w[63:32]};
            psd_pkg::PSD_EVEN_LANE_DUP_MOVE:
                sel = {src_w[95:64], src_w[95:64], src_w[31:0], src_w[31:0]};
            psd_pkg::PSD_QUAD_DUP_MOVE:         sel = {src_w[63:0], src_w[63:0]};
            psd_pkg::PSD_HORIZ_ADD_WORD:        sel = hw_add;
            psd_pkg::PSD_HORIZ_ADD_WORD_SAT:    sel = hw_adds;
            psd_pkg::PSD_HORIZ_ADD_DWORD:       sel = hd_add;
            psd_pkg::PSD_HORIZ_SUB_WORD:        sel = hw_sub;
            psd_pkg::PSD_HORIZ_SUB_WORD_SAT:    sel = hw_subs;
            psd_pkg::PSD_HORIZ_SUB_DWORD:       sel = hd_sub;
            psd_pkg::PSD_ABS_BYTE:              sel = abs_b;
            psd_pkg::PSD_ABS_WORD:              sel = abs_w;
            psd_pkg::PSD_ABS_DWORD:             sel = abs_d;
            psd_pkg::PSD_BYTE_MUL_ADD_SAT:      sel = madd;
            psd_pkg::PSD_ROUNDED_SCALED_HIGH_MUL: sel = mhrs;
            psd_pkg::PSD_COND_SIGN_BYTE:        sel = sg_b;
            psd_pkg::PSD_COND_SIGN_WORD:        sel = sg_w;
            psd_pkg::PSD_COND_SIGN_DWORD:       sel = sg_d;
            default:                            sel = 128'h0;
        endcase
    end

    // Narrow operations clear the upper half; duplicate moves are always full width.
    assign io.res = (io.wide || io.op == psd_pkg::PSD_ODD_LANE_DUP_MOVE
                     || io.op == psd_pkg::PSD_EVEN_LANE_DUP_MOVE
                     || io.op == psd_pkg::PSD_QUAD_DUP_MOVE) ? sel : {64'h0, sel[63:0]};
endmodule : psd_lanes

// [logic/psd_op_if.sv]
/*
 Interface carrying operands and operation from the top to the lane-arithmetic module.
 Assumes all signals are combinational within one clock cycle.
*/
`timescale 1ns/10ps
interface psd_op_if;
    psd_pkg::psd_op_t op;
    logic             wide;
    logic [127:0]     dst;
    logic [127:0]     src;
    logic [127:0]     res;

    modport top (output op, output wide, output dst, output src, input res);
    modport alu (input op, input wide, input dst, input src, output res);
endinterface : psd_op_if

// [logic/psd_pkg.sv]
/*
 Package of the packed-integer SIMD datapath: operation codes, widths and latency.
 Assumes the decoder maps its instruction encodings onto these operation codes.
*/
package psd_pkg;

    localparam int VEC_W       = 128;
    localparam int HALF_W      = 64;
    localparam int RESULT_LAT  = 1;
    localparam int SHIFT_W     = 8;
    localparam int RND_INC     = 1;
    localparam int MHI_TOP     = 31;
    localparam int MHI_LSB     = 14;

    typedef enum logic [4:0] {
        PSD_NOP,
        PSD_ODD_LANE_DUP_MOVE,
        PSD_EVEN_LANE_DUP_MOVE,
        PSD_QUAD_DUP_MOVE,
        PSD_HORIZ_ADD_WORD,
        PSD_HORIZ_ADD_WORD_SAT,
        PSD_HORIZ_ADD_DWORD,
        PSD_HORIZ_SUB_WORD,
        PSD_HORIZ_SUB_WORD_SAT,
        PSD_HORIZ_SUB_DWORD,
        PSD_ABS_BYTE,
        PSD_ABS_WORD,
        PSD_ABS_DWORD,
        PSD_BYTE_MUL_ADD_SAT,
        PSD_ROUNDED_SCALED_HIGH_MUL,
        PSD_BYTE_SHUFFLE,
        PSD_COND_SIGN_BYTE,
        PSD_COND_SIGN_WORD,
        PSD_COND_SIGN_DWORD,
        PSD_ALIGN_RIGHT_CONCAT
    } psd_op_t;

endpackage : psd_pkg

// [logic/psd_shuffle.sv]
/*
 Byte shuffle and align-right network.
 Assumes operands are stable within the cycle; output is combinational.
*/
`timescale 1ns/10ps
module psd_shuffle #(
    parameter int NBYTES = 16
) (
    // Operands
    input  wire logic [8*NBYTES-1:0] dst,
    input  wire logic [8*NBYTES-1:0] src,
    input  wire logic [7:0]          imm,
    input  wire logic                wide,
    // Results
    output logic      [8*NBYTES-1:0] shuf_res,
    output logic      [8*NBYTES-1:0] align_res
);
    logic [16*NBYTES-1:0] cat_w;
    logic [16*NBYTES-1:0] cat_sh;
    logic [7:0]           cnt_w;

    genvar g;
    generate
        for (g = 0; g < NBYTES; g++) begin : g_byte
            wire logic [7:0] ctl = src[8*g +: 8];
            wire logic [3:0] idx = wide ? ctl[3:0] : {1'b0, ctl[2:0]};
            assign shuf_res[8*g +: 8] = ctl[7] ? 8'h00 : dst[8*idx +: 8];
        end
    endgenerate

    // Narrow operands occupy the low half; the low destination half is packed above the low source half.
    assign cat_w = wide ? {dst, src} : {{NBYTES{8'h00}}, dst[63:0], src[63:0]};
    assign cnt_w = imm;
    assign cat_sh = (cnt_w >= 8'(2 * NBYTES)) ? '0 : (cat_w >> {cnt_w, 3'b000});
    assign align_res = wide ? cat_sh[8*NBYTES-1:0] : {64'h0, cat_sh[63:0]};
endmodule : psd_shuffle

// [test/psd_datapath_monitor.sv]
/*
 Checker on the top ports of the packed-integer SIMD datapath.
 Assumes it is bound to psd_datapath and sees ref_clk, srst and all issue and result ports.
*/
`timescale 1ns/10ps
module psd_datapath_monitor (
    // Clock and reset
    input wire logic             ref_clk,
    input wire logic             srst,
    input wire logic             clk_en,
    // Issue
    input wire logic             issue_valid,
    input wire psd_pkg::psd_op_t op,
    input wire logic             wide,
    input wire logic [127:0]     dst_in,
    input wire logic [127:0]     src_in,
    input wire logic [7:0]       imm,
    // Result
    input wire logic             res_valid,
    input wire logic [127:0]     res_data,
    input wire logic [127:0]     src_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_any;
        issue_valid && clk_en;
    endsequence
    sequence s_take(psd_pkg::psd_op_t o);
        issue_valid && clk_en && op == o;
    endsequence
    AST_ANSWER: assert property (s_any |=> res_valid)
        else $error("no result one cycle after an issue");
    AST_NO_SPURIOUS: assert property (res_valid && $past(clk_en) |-> $past(issue_valid))
        else $error("result without an issue");
    AST_FREEZE: assert property (!clk_en |=> $stable(res_data) && $stable(res_valid))
        else $error("state moved while the clock enable was low");
    AST_MASK_KEPT: assert property (s_any |=> src_out == $past(src_in))
        else $error("control operand copy changed");
    AST_ODD_DUP: assert property (s_take(psd_pkg::PSD_ODD_LANE_DUP_MOVE) |=> res_data ==
        {{2{$past(src_in[127:96])}}, {2{$past(src_in[63:32])}}})
        else $error("odd lane duplicate wrong");
    AST_EVEN_DUP: assert property (s_take(psd_pkg::PSD_EVEN_LANE_DUP_MOVE) |=> res_data ==
        {{2{$past(src_in[95:64])}}, {2{$past(src_in[31:0])}}})
        else $error("even lane duplicate wrong");
    AST_QUAD_DUP: assert property (s_take(psd_pkg::PSD_QUAD_DUP_MOVE) |=>
        res_data == {2{$past(src_in[63:0])}})
        else $error("quad duplicate wrong");
    AST_NARROW_TOP: assert property (issue_valid && clk_en && !wide &&
        op == psd_pkg::PSD_ABS_BYTE |=> res_data[127:64] == 64'h0)
        else $error("narrow result has a nonzero upper half");
    AST_SHUF_ZERO: assert property (issue_valid && clk_en && src_in[7] &&
        op == psd_pkg::PSD_BYTE_SHUFFLE |=> res_data[7:0] == 8'h00)
        else $error("shuffle byte not forced to zero");
    AST_ALIGN_ZERO: assert property (issue_valid && clk_en && wide && imm == 8'h00 &&
        op == psd_pkg::PSD_ALIGN_RIGHT_CONCAT |=> res_data == $past(src_in))
        else $error("align by zero bytes did not return the source");
endmodule : psd_datapath_monitor
bind psd_datapath psd_datapath_monitor u_psd_datapath_monitor (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .issue_valid(issue_valid),
    .op(op), .wide(wide), .dst_in(dst_in), .src_in(src_in), .imm(imm),
    .res_valid(res_valid), .res_data(res_data), .src_out(src_out)
);

// [test/psd_decode_model.sv]
/*
 Model of the decode and register-file side that issues operations to the datapath.
 Assumes the bench calls drive once per cycle; it changes its outputs at the falling edge.
*/
`timescale 1ns/10ps
module psd_decode_model (
    // Clock
    input wire logic           ref_clk,
    // Issue towards the datapath
    output logic               clk_en      = 1'b1,
    output logic               issue_valid = 1'b0,
    output psd_pkg::psd_op_t   op          = psd_pkg::PSD_NOP,
    output logic               wide        = 1'b0,
    output logic [127:0]       dst_in      = 128'h0,
    output logic [127:0]       src_in      = 128'h0,
    output logic [7:0]         imm         = 8'h00
);
    // Idle slots invert the operands so that stale data can never pass as valid.
    task automatic drive(input logic en, input logic iv, input psd_pkg::psd_op_t o,
                         input logic w, input logic [127:0] d, input logic [127:0] s,
                         input logic [7:0] im);
        @(negedge ref_clk);
        clk_en      = en;
        issue_valid = iv;
        op          = o;
        wide        = w;
        dst_in      = iv ? d : ~dst_in;
        src_in      = iv ? s : ~src_in;
        imm         = im;
    endtask : drive
endmodule : psd_decode_model

// [test/tb_top.sv]
/*
 Self-checking bench: random issues back to back with stalls and extreme operands.
 Assumes a registered result one enabled cycle after each issue.
*/
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en, issue_valid, wide, res_valid;
    psd_pkg::psd_op_t op, o;
    logic [127:0] dst_in, src_in, res_data, src_out, d, s, ex, pe, ps;
    logic [7:0] imm, im;
    logic [31:0] rnd = 32'h81F6;
    logic en, iv, wd, pend = 1'b0, pen = 1'b0, known, pk;
    int miscompares = 0;
    int checks = 0;
    int pg = 0;
    initial forever #10 ref_clk = ~ref_clk;
    psd_decode_model u_psd_decode_model (.ref_clk(ref_clk), .clk_en(clk_en),
        .issue_valid(issue_valid), .op(op), .wide(wide), .dst_in(dst_in),
        .src_in(src_in), .imm(imm));
    psd_datapath u_psd_datapath (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
        .issue_valid(issue_valid), .op(op), .wide(wide), .dst_in(dst_in), .src_in(src_in),
        .imm(imm), .res_valid(res_valid), .res_data(res_data), .src_out(src_out));
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'hA3000000 : x >> 1;
    endfunction : lfsr
    function automatic logic [15:0] sat16(int v);
        return v > 32767 ? 16'h7FFF : (v < -32768 ? 16'h8000 : v[15:0]);
    endfunction : sat16
    function automatic bit exp_f(psd_pkg::psd_op_t o, logic w, logic [127:0] d,
                                 logic [127:0] s, logic [7:0] im, output logic [127:0] r);
        logic [255:0] c;
        logic [15:0]  a, b;
        logic [31:0]  p, x, y, m;
        int           n, q, t, e;
        r = '0;
        n = w ? 16 : 8;
        q = n / 4;
        exp_f = 1'b1;
        case (o)
            psd_pkg::PSD_HORIZ_ADD_WORD, psd_pkg::PSD_HORIZ_ADD_WORD_SAT,
            psd_pkg::PSD_HORIZ_SUB_WORD, psd_pkg::PSD_HORIZ_SUB_WORD_SAT: begin
                for (int i = 0; i < n / 2; i++) begin
                    {b, a} = i < q ? d[32*i+:32] : s[32*(i-q)+:32];
                    t = (o == psd_pkg::PSD_HORIZ_ADD_WORD || o == psd_pkg::PSD_HORIZ_ADD_WORD_SAT)
                        ? $signed(a) + $signed(b) : $signed(a) - $signed(b);
                    r[16*i+:16] = (o == psd_pkg::PSD_HORIZ_ADD_WORD_SAT ||
                        o == psd_pkg::PSD_HORIZ_SUB_WORD_SAT) ? sat16(t) : t[15:0];
                end
            end
            psd_pkg::PSD_HORIZ_ADD_DWORD, psd_pkg::PSD_HORIZ_SUB_DWORD:
                for (int i = 0; i < n / 4; i++) begin
                    {y, x} = i < q / 2 ? d[64*i+:64] : s[64*(i-q/2)+:64];
                    r[32*i+:32] = o == psd_pkg::PSD_HORIZ_ADD_DWORD ? x + y : x - y;
                end
            psd_pkg::PSD_BYTE_MUL_ADD_SAT:
                for (int i = 0; i < n / 2; i++) begin
                    t = $signed({1'b0, d[16*i+:8]}) * $signed(s[16*i+:8]) +
                        $signed({1'b0, d[16*i+8+:8]}) * $signed(s[16*i+8+:8]);
                    r[16*i+:16] = sat16(t);
                end
            psd_pkg::PSD_ROUNDED_SCALED_HIGH_MUL:
                for (int i = 0; i < n / 2; i++) begin
                    p = $signed(d[16*i+:16]) * $signed(s[16*i+:16]);
                    t = ($signed(p) >>> 14) + 1;
                    r[16*i+:16] = t[16:1];
                end
            psd_pkg::PSD_ABS_BYTE, psd_pkg::PSD_ABS_WORD, psd_pkg::PSD_ABS_DWORD,
            psd_pkg::PSD_COND_SIGN_BYTE, psd_pkg::PSD_COND_SIGN_WORD,
            psd_pkg::PSD_COND_SIGN_DWORD: begin
                e = (o == psd_pkg::PSD_ABS_BYTE || o == psd_pkg::PSD_COND_SIGN_BYTE) ? 8
                  : (o == psd_pkg::PSD_ABS_WORD || o == psd_pkg::PSD_COND_SIGN_WORD) ? 16 : 32;
                m = 32'hFFFFFFFF >> (32 - e);
                for (int i = 0; i < 8 * n / e; i++) begin
                    x = 32'(s >> (e * i)) & m;
                    y = 32'(d >> (e * i)) & m;
                    if (o <= psd_pkg::PSD_ABS_DWORD) y = x[e-1] ? 32'h0 - x : x;
                    else y = x[e-1] ? 32'h0 - y : (x == 32'h0 ? 32'h0 : y);
                    r = r | (128'(y & m) << (e * i));
                end
            end
            psd_pkg::PSD_BYTE_SHUFFLE:
                for (int i = 0; i < n; i++) begin
                    a = {8'h00, s[8*i+:8]};
                    r[8*i+:8] = a[7] ? 8'h00 : d[8*(w ? a[3:0] : a[2:0])+:8];
                end
            psd_pkg::PSD_ALIGN_RIGHT_CONCAT: begin
                c = w ? {d, s} : {128'h0, d[63:0], s[63:0]};
                c = c >> (8 * int'(im));
                r = w ? c[127:0] : {64'h0, c[63:0]};
            end
            psd_pkg::PSD_ODD_LANE_DUP_MOVE: r = {{2{s[127:96]}}, {2{s[63:32]}}};
            psd_pkg::PSD_EVEN_LANE_DUP_MOVE: r = {{2{s[95:64]}}, {2{s[31:0]}}};
            psd_pkg::PSD_QUAD_DUP_MOVE: r = {2{s[63:0]}};
            default: exp_f = 1'b0;
        endcase
    endfunction : exp_f
    task automatic cmp(input logic [127:0] got, input logic [127:0] want);
        checks++;
        if (got !== want) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : cmp
    task automatic print_verdict();
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // About 420 cycles are needed; the limit allows 1000.
    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (12) @(negedge ref_clk);
        srst = 1'b0;
        for (int it = 0; it < 400; it++) begin
            for (int k = 0; k < 4; k++) begin
                rnd = lfsr(rnd);
                d[32*k+:32] = rnd;
                rnd = lfsr(rnd);
                s[32*k+:32] = rnd;
            end
            rnd = lfsr(rnd);
            if (it % 5 == 0) d = {8{16'h8000}};
            if (it % 5 == 0) s = it % 10 == 0 ? d : ~d;
            // The first 38 issues sweep every operation once wide and once narrow.
            wd = it < 38 ? it < 19 : rnd[25];
            o = it < 38 ? psd_pkg::psd_op_t'(1 + it % 19)
                        : psd_pkg::psd_op_t'(1 + rnd[20:8] % 19);
            im = (it % 7 == 0 || it == 18) ? 8'h00 : {2'b00, rnd[5:0]};
            en = it < 38 || rnd[31:29] != 3'b000;
            iv = it < 38 || rnd[28:26] != 3'b000;
            u_psd_decode_model.drive(en, iv, o, wd, d, s, im);
            if (pend) cmp({127'h0, res_valid}, 128'h1);
            else if (pen) cmp({127'h0, res_valid}, 128'h0);
            if (pend) cmp(src_out, ps);
            if (pend && pk && pg == 0) cmp(res_data, pe);
            if (pend && pk && pg == 1) cmp(res_data, pe);
            if (pend && pk && pg == 2) cmp(res_data, pe);
            if (pend && pk && pg == 3) cmp(res_data, pe);
            known = exp_f(o, wd, d, s, im, ex);
            pen = en;
            pend = en && iv;
            pk = known;
            pe = ex;
            ps = s;
            pg = o < psd_pkg::PSD_HORIZ_ADD_WORD ? 0 : o < psd_pkg::PSD_ABS_BYTE ? 1 :
                 o < psd_pkg::PSD_BYTE_SHUFFLE ? 2 : 3;
        end
        // A reset in mid-run clears the outputs, and the next issue still completes.
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        cmp(res_data, 128'h0);
        cmp(src_out, 128'h0);
        cmp({127'h0, res_valid}, 128'h0);
        u_psd_decode_model.drive(1'b1, 1'b1, psd_pkg::PSD_QUAD_DUP_MOVE, 1'b0, d, s, 8'h00);
        u_psd_decode_model.drive(1'b1, 1'b0, psd_pkg::PSD_NOP, 1'b0, d, s, 8'h00);
        cmp(res_data, {2{s[63:0]}});
        print_verdict();
    end
endmodule : tb_top
